//--- hw/amp_diag_params.svh
// Timing counts, field positions and reset values for the amplifier channel control block
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
`ifndef AMP_DIAG_PARAMS_SVH
`define AMP_DIAG_PARAMS_SVH

`define CLK_PERIOD_NS 20
`define RAMP_STEP_NS 10000
`define RAMP_STEP_CYC ((`RAMP_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DIAG_PHASE_NS 50000
`define DIAG_PHASE_CYC ((`DIAG_PHASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TWEET_PERIOD_NS 2000
`define TWEET_PERIOD_CYC ((`TWEET_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define RES_SHORT_GROUND 0
`define RES_SHORT_SUPPLY 1
`define RES_SHORTED_LOAD 2
`define RES_OPEN_LOAD 3

`define GAIN_CODE_RST 8'h00
`define CLIP_MODE_RST 2'h1
`define OFFSET_EN_RST 1'b1

`endif

//--- hw/amp_diag_pkg.sv
// Types shared by the amplifier channel control block
package amp_diag_pkg;

    typedef enum logic [4:0] {
        RS_HIZ  = 5'h01,
        RS_MUTE = 5'h02,
        RS_UP   = 5'h04,
        RS_PLAY = 5'h08,
        RS_DOWN = 5'h10
    } ramp_state_t;

    typedef enum logic [5:0] {
        DS_IDLE    = 6'h01,
        DS_SUPPLY  = 6'h02,
        DS_GROUND  = 6'h04,
        DS_SHORTED = 6'h08,
        DS_OPEN    = 6'h10,
        DS_DONE    = 6'h20
    } diag_state_t;

    typedef enum logic [1:0] {
        CM_CLIP  = 2'h0,
        CM_WARN  = 2'h1,
        CM_BOTH  = 2'h2,
        CM_TWEET = 2'h3
    } clip_mode_t;

    typedef enum logic [1:0] {
        GAIN_12DB = 2'h0,
        GAIN_20DB = 2'h1,
        GAIN_26DB = 2'h2,
        GAIN_32DB = 2'h3
    } gain_code_t;

endpackage

//--- hw/amp_gain_ramp.sv
// Per-channel gain ramp and output state sequencer
`include "amp_diag_params.svh"
`timescale 1ns/100ps
`default_nettype none

module amp_gain_ramp #(
    parameter int unsigned STEP_CYC = `RAMP_STEP_CYC,
    parameter int unsigned LEVEL_W = 6
) (
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_play,
    input wire logic i_hiz_req,
    input wire logic i_fault,
    input wire logic i_hold_hiz,
    output logic o_hiz,
    output logic [LEVEL_W-1:0] o_level
);

    localparam logic [15:0] STEP_LAST = 16'(STEP_CYC - 1);
    localparam logic [LEVEL_W-1:0] LEVEL_TOP = '1;

    amp_diag_pkg::ramp_state_t state_q;
    amp_diag_pkg::ramp_state_t state_d;
    logic [15:0] step_cnt_q;
    logic step_tick;

    assign step_tick = (step_cnt_q == STEP_LAST);

    // ------------------------------------------------------------------------
    // State sequencing
    // ------------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            amp_diag_pkg::RS_HIZ: begin
                if (!i_hiz_req && !i_hold_hiz) begin
                    state_d = amp_diag_pkg::RS_MUTE;
                end
            end
            amp_diag_pkg::RS_MUTE: begin
                if (i_hiz_req) begin
                    state_d = amp_diag_pkg::RS_HIZ;
                end else if (i_play) begin
                    state_d = amp_diag_pkg::RS_UP;
                end
            end
            amp_diag_pkg::RS_UP: begin
                if (!i_play || i_hiz_req) begin
                    state_d = amp_diag_pkg::RS_DOWN;
                end else if (step_tick && o_level == LEVEL_TOP) begin
                    state_d = amp_diag_pkg::RS_PLAY;
                end
            end
            amp_diag_pkg::RS_PLAY: begin
                if (!i_play || i_hiz_req) begin
                    state_d = amp_diag_pkg::RS_DOWN;
                end
            end
            amp_diag_pkg::RS_DOWN: begin
                if (i_play && !i_hiz_req) begin
                    state_d = amp_diag_pkg::RS_UP;
                end else if (step_tick && o_level == '0) begin
                    state_d = amp_diag_pkg::RS_MUTE;
                end
            end
            default: begin
                state_d = amp_diag_pkg::RS_HIZ;
            end
        endcase
        if (i_fault) begin
            state_d = amp_diag_pkg::RS_HIZ;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_q <= amp_diag_pkg::RS_HIZ;
            o_hiz <= 1'b1;
        end else begin
            state_q <= state_d;
            o_hiz <= (state_d == amp_diag_pkg::RS_HIZ);
        end
    end

    // ------------------------------------------------------------------------
    // Ramp step timer and gain level
    // ------------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            step_cnt_q <= 16'h0000;
        end else if (step_tick || state_q == amp_diag_pkg::RS_HIZ) begin
            step_cnt_q <= 16'h0000;
        end else begin
            step_cnt_q <= step_cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_level <= '0;
        end else if (i_fault || state_q == amp_diag_pkg::RS_HIZ) begin
            o_level <= '0;
        end else if (step_tick && state_q == amp_diag_pkg::RS_UP && o_level != LEVEL_TOP) begin
            o_level <= o_level + 1'b1;
        end else if (step_tick && state_q == amp_diag_pkg::RS_DOWN && o_level != '0) begin
            o_level <= o_level - 1'b1;
        end
    end

endmodule // amp_gain_ramp

`default_nettype wire

//--- hw/amp_channel_diag_control.sv
// Four-channel amplifier control: gain ramps, faults, load diagnostics, tweeter test
`include "amp_diag_params.svh"
`timescale 1ns/100ps
`default_nettype none

module amp_channel_diag_control #(
    parameter int unsigned NUM_CH = 4,
    parameter int unsigned LEVEL_W = 6,
    parameter int unsigned RAMP_STEP_CYC = `RAMP_STEP_CYC,
    parameter int unsigned DIAG_PHASE_CYC = `DIAG_PHASE_CYC,
    parameter int unsigned TWEET_PERIOD_CYC = `TWEET_PERIOD_CYC
) (
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic [3:0] i_play_cmd,
    input wire logic [3:0] i_hiz_cmd,
    input wire logic [7:0] i_gain_sel,
    input wire logic i_offset_reduce_en,
    input wire logic [1:0] i_clip_mode,
    input wire logic i_overvoltage_fault,
    input wire logic i_undervoltage_fault,
    input wire logic i_overtemperature_fault,
    input wire logic [3:0] i_overcurrent_fault,
    input wire logic [3:0] i_dc_offset_fault,
    input wire logic i_diag_start,
    input wire logic [3:0] i_diag_ch_req,
    input wire logic [3:0] i_det_short_supply,
    input wire logic [3:0] i_det_short_ground,
    input wire logic [3:0] i_det_shorted_load,
    input wire logic [3:0] i_det_open_load,
    input wire logic i_tweet_start,
    input wire logic i_tweet_stop,
    input wire logic [1:0] i_tweet_ch,
    input wire logic [3:0] i_cycle_current_limiter,
    input wire logic [3:0] i_clip_detect,
    input wire logic i_overtemperature_warning,
    output logic [3:0] o_ch_hiz,
    output logic [23:0] o_ch_gain_level,
    output logic [7:0] o_gain_code,
    output logic o_offset_reduce_en,
    output logic o_diag_busy,
    output logic o_diag_full_level,
    output logic [15:0] o_diag_result,
    output logic o_tweet_active,
    output logic o_clip_warning_output
);

    localparam int unsigned SYNC_W = 36;
    localparam logic [15:0] PHASE_LAST = 16'(DIAG_PHASE_CYC - 1);
    localparam logic [15:0] TWEET_LAST = 16'(TWEET_PERIOD_CYC - 1);

    // ------------------------------------------------------------------------
    // Input synchronisers for analog comparators and fault detectors
    // ------------------------------------------------------------------------
    logic [SYNC_W-1:0] sync_meta_q;
    logic [SYNC_W-1:0] sync_q;
    logic [SYNC_W-1:0] sync_raw;

    assign sync_raw = {i_overvoltage_fault, i_undervoltage_fault, i_overtemperature_fault,
                       i_overcurrent_fault, i_dc_offset_fault, i_det_short_supply,
                       i_det_short_ground, i_det_shorted_load, i_det_open_load,
                       i_cycle_current_limiter, i_clip_detect, i_overtemperature_warning};

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sync_meta_q <= '0;
            sync_q <= '0;
        end else begin
            sync_meta_q <= sync_raw;
            sync_q <= sync_meta_q;
        end
    end

    logic ov_s;
    logic uv_s;
    logic ot_s;
    logic [3:0] oc_s;
    logic [3:0] dc_s;
    logic [3:0] supply_s;
    logic [3:0] ground_s;
    logic [3:0] shorted_s;
    logic [3:0] open_s;
    logic [3:0] limiter_s;
    logic [3:0] clip_s;
    logic otw_s;

    assign {ov_s, uv_s, ot_s, oc_s, dc_s, supply_s, ground_s, shorted_s, open_s,
            limiter_s, clip_s, otw_s} = sync_q;

    // ------------------------------------------------------------------------
    // Gain and offset reduction settings
    // ------------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_gain_code <= `GAIN_CODE_RST;
        end else begin
            o_gain_code <= i_gain_sel;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_offset_reduce_en <= `OFFSET_EN_RST;
        end else begin
            o_offset_reduce_en <= i_offset_reduce_en;
        end
    end

    // ------------------------------------------------------------------------
    // Per-channel ramp sequencers
    // ------------------------------------------------------------------------
    logic [3:0] ch_fault;
    logic [3:0] diag_hold;

    assign ch_fault = {4{ov_s | uv_s | ot_s}} | oc_s | dc_s;

    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
        amp_gain_ramp #(
            .STEP_CYC(RAMP_STEP_CYC),
            .LEVEL_W(LEVEL_W)
        ) u_ramp (
            .i_clk_sys(i_clk_sys),
            .i_arst_n(i_arst_n),
            .i_play(i_play_cmd[ch]),
            .i_hiz_req(i_hiz_cmd[ch]),
            .i_fault(ch_fault[ch]),
            .i_hold_hiz(diag_hold[ch]),
            .o_hiz(o_ch_hiz[ch]),
            .o_level(o_ch_gain_level[ch*LEVEL_W +: LEVEL_W])
        );
    end

    // ------------------------------------------------------------------------
    // Load diagnostic sequencer
    // ------------------------------------------------------------------------
    amp_diag_pkg::diag_state_t diag_state_q;
    logic [15:0] phase_cnt_q;
    logic [3:0] diag_ch_q;
    logic phase_end;
    logic diag_accept;
    logic [3:0] req_ok;

    assign req_ok = i_diag_ch_req & o_ch_hiz;
    assign diag_accept = i_diag_start && (diag_state_q == amp_diag_pkg::DS_IDLE)
                         && (req_ok != 4'h0) && !o_tweet_active;
    assign phase_end = (phase_cnt_q == PHASE_LAST);
    assign diag_hold = o_diag_busy ? diag_ch_q : 4'h0;

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            diag_state_q <= amp_diag_pkg::DS_IDLE;
        end else begin
            case (diag_state_q)
                amp_diag_pkg::DS_IDLE: begin
                    if (diag_accept) begin
                        diag_state_q <= amp_diag_pkg::DS_SUPPLY;
                    end
                end
                amp_diag_pkg::DS_SUPPLY: begin
                    if (phase_end) begin
                        diag_state_q <= amp_diag_pkg::DS_GROUND;
                    end
                end
                amp_diag_pkg::DS_GROUND: begin
                    if (phase_end && o_diag_full_level) begin
                        diag_state_q <= amp_diag_pkg::DS_SHORTED;
                    end else if (phase_end) begin
                        diag_state_q <= amp_diag_pkg::DS_DONE;
                    end
                end
                amp_diag_pkg::DS_SHORTED: begin
                    if (phase_end) begin
                        diag_state_q <= amp_diag_pkg::DS_OPEN;
                    end
                end
                amp_diag_pkg::DS_OPEN: begin
                    if (phase_end) begin
                        diag_state_q <= amp_diag_pkg::DS_DONE;
                    end
                end
                amp_diag_pkg::DS_DONE: begin
                    diag_state_q <= amp_diag_pkg::DS_IDLE;
                end
                default: begin
                    diag_state_q <= amp_diag_pkg::DS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            phase_cnt_q <= 16'h0000;
        end else if (diag_state_q == amp_diag_pkg::DS_IDLE
                     || diag_state_q == amp_diag_pkg::DS_DONE || phase_end) begin
            phase_cnt_q <= 16'h0000;
        end else begin
            phase_cnt_q <= phase_cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            diag_ch_q <= 4'h0;
            o_diag_full_level <= 1'b0;
        end else if (diag_accept) begin
            o_diag_full_level <= (o_ch_hiz == 4'hf);
            diag_ch_q <= (o_ch_hiz == 4'hf) ? 4'hf : req_ok;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_diag_busy <= 1'b0;
        end else if (diag_accept) begin
            o_diag_busy <= 1'b1;
        end else if (diag_state_q == amp_diag_pkg::DS_DONE) begin
            o_diag_busy <= 1'b0;
        end
    end

    // Results clear at the start of a run and collect at each phase end
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_diag_result <= 16'h0000;
        end else if (diag_accept) begin
            o_diag_result <= 16'h0000;
        end else if (phase_end) begin
            for (int ch = 0; ch < 4; ch++) begin
                if (diag_ch_q[ch]) begin
                    case (diag_state_q)
                        amp_diag_pkg::DS_SUPPLY: begin
                            o_diag_result[ch*4 + `RES_SHORT_SUPPLY] <= supply_s[ch];
                        end
                        amp_diag_pkg::DS_GROUND: begin
                            o_diag_result[ch*4 + `RES_SHORT_GROUND] <= ground_s[ch];
                        end
                        amp_diag_pkg::DS_SHORTED: begin
                            o_diag_result[ch*4 + `RES_SHORTED_LOAD] <= shorted_s[ch];
                        end
                        amp_diag_pkg::DS_OPEN: begin
                            o_diag_result[ch*4 + `RES_OPEN_LOAD] <= open_s[ch];
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Tweeter detection pulse density
    // ------------------------------------------------------------------------
    logic [1:0] tweet_ch_q;
    logic [15:0] win_cnt_q;
    logic [15:0] hit_cnt_q;
    logic [15:0] duty_q;
    logic win_end;
    logic tweet_pulse;

    assign win_end = (win_cnt_q == TWEET_LAST);
    assign tweet_pulse = o_tweet_active && (win_cnt_q < duty_q);

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_tweet_active <= 1'b0;
            tweet_ch_q <= 2'h0;
        end else if (i_tweet_start && !o_diag_busy) begin
            o_tweet_active <= 1'b1;
            tweet_ch_q <= i_tweet_ch;
        end else if (i_tweet_stop) begin
            o_tweet_active <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            win_cnt_q <= 16'h0000;
        end else if (win_end || !o_tweet_active) begin
            win_cnt_q <= 16'h0000;
        end else begin
            win_cnt_q <= win_cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            hit_cnt_q <= 16'h0000;
            duty_q <= 16'h0000;
        end else if (!o_tweet_active) begin
            hit_cnt_q <= 16'h0000;
            duty_q <= 16'h0000;
        end else if (win_end) begin
            duty_q <= hit_cnt_q + {15'h0000, limiter_s[tweet_ch_q]};
            hit_cnt_q <= 16'h0000;
        end else if (limiter_s[tweet_ch_q]) begin
            hit_cnt_q <= hit_cnt_q + 16'h0001;
        end
    end

    // ------------------------------------------------------------------------
    // Clip and warning output selector
    // ------------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_clip_warning_output <= 1'b0;
        end else begin
            case (amp_diag_pkg::clip_mode_t'(i_clip_mode))
                amp_diag_pkg::CM_CLIP: begin
                    o_clip_warning_output <= |clip_s;
                end
                amp_diag_pkg::CM_WARN: begin
                    o_clip_warning_output <= otw_s;
                end
                amp_diag_pkg::CM_BOTH: begin
                    o_clip_warning_output <= (|clip_s) | otw_s;
                end
                amp_diag_pkg::CM_TWEET: begin
                    o_clip_warning_output <= tweet_pulse;
                end
                default: begin
                    o_clip_warning_output <= 1'b0;
                end
            endcase
        end
    end

endmodule // amp_channel_diag_control

`default_nettype wire

//--- bench/amp_diag_monitor.sv
// Concurrent checks on the amplifier channel control ports
`timescale 1ns/100ps
`default_nettype none
module amp_diag_monitor (
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic [7:0] i_gain_sel,
    input wire logic i_offset_reduce_en,
    input wire logic [1:0] i_clip_mode,
    input wire logic [3:0] i_overcurrent_fault,
    input wire logic i_diag_start,
    input wire logic [3:0] i_diag_ch_req,
    input wire logic [3:0] i_clip_detect,
    input wire logic [3:0] o_ch_hiz,
    input wire logic [23:0] o_ch_gain_level,
    input wire logic [7:0] o_gain_code,
    input wire logic o_offset_reduce_en,
    input wire logic o_diag_busy,
    input wire logic o_diag_full_level,
    input wire logic [15:0] o_diag_result,
    input wire logic o_tweet_active,
    input wire logic o_clip_warning_output
);
// ----------------------------------------
// Assertions
// ----------------------------------------
default clocking @(posedge i_clk_sys); endclocking
default disable iff (!i_arst_n);
a_gain_copy: assert property (
    {o_gain_code, o_offset_reduce_en} == $past({i_gain_sel, i_offset_reduce_en}))
    else $error("gain or offset setting not copied");
a_ramp_step: assert property (
    o_ch_gain_level[5:0] > $past(o_ch_gain_level[5:0])
    |-> o_ch_gain_level[5:0] == $past(o_ch_gain_level[5:0]) + 6'h1)
    else $error("gain level jumped");
a_fault_fast: assert property (
    $rose(i_overcurrent_fault[0]) ##3 i_overcurrent_fault[0]
    |-> o_ch_hiz[0] && o_ch_gain_level[5:0] == 6'h0)
    else $error("fault did not force high impedance");
a_diag_accept: assert property (
    i_diag_start && !o_diag_busy && !o_tweet_active && (i_diag_ch_req & o_ch_hiz) != 4'h0
    |=> o_diag_busy && o_diag_result == 16'h0 && o_diag_full_level == ($past(o_ch_hiz) == 4'hf))
    else $error("diagnostic start not taken correctly");
a_diag_refuse: assert property (
    i_diag_start && !o_diag_busy && (i_diag_ch_req & o_ch_hiz) == 4'h0 |=> !o_diag_busy)
    else $error("diagnostic started on driven channel");
a_full_hiz: assert property (
    o_diag_busy && o_diag_full_level |-> o_ch_hiz == 4'hf)
    else $error("channel left high impedance in full run");
a_result_hold: assert property (
    !o_diag_busy && !$past(o_diag_busy) |-> $stable(o_diag_result))
    else $error("results changed while idle");
a_clip_quiet: assert property (
    (i_clip_mode == amp_diag_pkg::CM_CLIP && i_clip_detect == 4'h0) [*5]
    |-> !o_clip_warning_output)
    else $error("clip output high without clip");
endmodule // amp_diag_monitor
bind amp_channel_diag_control amp_diag_monitor u_monitor (.i_clk_sys, .i_arst_n, .i_gain_sel,
    .i_offset_reduce_en, .i_clip_mode, .i_overcurrent_fault, .i_diag_start, .i_diag_ch_req,
    .i_clip_detect, .o_ch_hiz, .o_ch_gain_level, .o_gain_code, .o_offset_reduce_en,
    .o_diag_busy, .o_diag_full_level, .o_diag_result, .o_tweet_active, .o_clip_warning_output);
`default_nettype wire

//--- bench/tone_burst_model.sv
// Host-side tone burst source driving the current-limit trip inputs
`timescale 1ns/100ps
`default_nettype none
module tone_burst_model (
    input wire logic i_en,
    input wire logic [1:0] i_ch,
    output logic [3:0] o_trip
);
logic tone = 1'b0;
// Burst toggles only while enabled, idles low otherwise
always begin
    #80;
    tone = i_en ? ~tone : 1'b0;
end
// One channel under test at a time
assign o_trip = {3'h0, tone} << i_ch;
endmodule // tone_burst_model
`default_nettype wire

//--- bench/tb.sv
// Testbench for the amplifier channel control block
`timescale 1ns/100ps
`default_nettype none
module tb;
// ----------------------------------------
// Signals and instances
// ----------------------------------------
logic i_clk_sys = 0, i_arst_n = 0, i_offset_reduce_en = 1, i_diag_start = 0, tone_en = 0;
logic i_tweet_start = 0, i_tweet_stop = 0, i_overtemperature_warning = 0, o_offset_reduce_en;
logic i_overvoltage_fault = 0, i_undervoltage_fault = 0, i_overtemperature_fault = 0;
logic [3:0] i_play_cmd = 0, i_hiz_cmd = 4'hf, i_diag_ch_req = 0, i_clip_detect = 0;
logic [3:0] i_det_short_supply = 0, i_det_short_ground = 0, i_det_shorted_load = 0;
logic [3:0] i_det_open_load = 0, i_overcurrent_fault = 0, i_dc_offset_fault = 0, o_ch_hiz;
logic [7:0] i_gain_sel = 0, o_gain_code;
logic [1:0] i_clip_mode = 2'h1, i_tweet_ch = 0;
logic [23:0] o_ch_gain_level;
logic [15:0] o_diag_result;
logic o_diag_busy, o_diag_full_level, o_tweet_active, o_clip_warning_output;
wire logic [3:0] i_cycle_current_limiter;
int fails = 0, checks_done = 0;
always #10 i_clk_sys = ~i_clk_sys;
tone_burst_model u_tone (.i_en(tone_en), .i_ch(i_tweet_ch), .o_trip(i_cycle_current_limiter));
amp_channel_diag_control #(.RAMP_STEP_CYC(2), .DIAG_PHASE_CYC(8), .TWEET_PERIOD_CYC(8)) DUT (
    .i_clk_sys, .i_arst_n, .i_play_cmd, .i_hiz_cmd, .i_gain_sel, .i_offset_reduce_en,
    .i_clip_mode, .i_overvoltage_fault, .i_undervoltage_fault,
    .i_overtemperature_fault, .i_overcurrent_fault, .i_dc_offset_fault,
    .i_diag_start, .i_diag_ch_req, .i_det_short_supply, .i_det_short_ground,
    .i_det_shorted_load, .i_det_open_load, .i_tweet_start, .i_tweet_stop, .i_tweet_ch,
    .i_cycle_current_limiter, .i_clip_detect, .i_overtemperature_warning, .o_ch_hiz,
    .o_ch_gain_level, .o_gain_code, .o_offset_reduce_en, .o_diag_busy, .o_diag_full_level,
    .o_diag_result, .o_tweet_active, .o_clip_warning_output);
// ----------------------------------------
// Shared tasks
// ----------------------------------------
task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
        fails++;
        $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
endtask
task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
endtask
task automatic diag_run(input logic [3:0] req, output int n);
    n = 0;
    i_diag_ch_req = req;
    i_diag_start = 1;
    cyc(1);
    i_diag_start = 0;
    // Request mask stays untouched until the run ends; start is a one-cycle pulse
    while (o_diag_busy === 1'b1 && n < 100) begin
        cyc(1);
        n++;
    end
    cyc(1);
endtask
task automatic complete_run;
    if (fails == 0 && checks_done > 0) begin
        $display("SIMULATION PASSED");
    end else begin
        $display("SIMULATION FAILED");
    end
    $finish;
endtask
// ----------------------------------------
// Scenarios
// ----------------------------------------
task automatic t_power_up;
    int n;
    chk(o_ch_hiz, 4'hf);
    i_det_short_supply = 4'h1;
    i_det_open_load = 4'h2;
    i_det_shorted_load = 4'h4;
    cyc(4);
    diag_run(4'h1, n);
    chk(o_diag_full_level, 1'b1);
    chk(n == 4 * 8 + 1, 1'b1);
    chk(o_diag_result, 16'h0482);
    i_det_short_supply = 4'h0;
    i_det_shorted_load = 4'h0;
endtask
task automatic t_play;
    int n = 0;
    i_gain_sel = 8'he4;
    i_offset_reduce_en = 0;
    i_hiz_cmd = 4'he;
    i_play_cmd = 4'h1;
    cyc(2);
    chk(o_gain_code, 8'he4);
    chk(o_offset_reduce_en, 1'b0);
    chk(o_ch_hiz, 4'he);
    while (o_ch_gain_level[5:0] !== 6'h3f && n < 400) begin
        cyc(1);
        n++;
    end
    chk(n >= 63, 1'b1);
endtask
task automatic t_reduced;
    int n;
    i_det_short_ground = 4'h3;
    cyc(4);
    diag_run(4'h1, n);
    chk(o_diag_busy, 1'b0);
    chk(o_diag_result, 16'h0482);
    diag_run(4'h2, n);
    chk(o_diag_full_level, 1'b0);
    chk(n == 2 * 8 + 1, 1'b1);
    chk(o_diag_result, 16'h0010);
    i_det_short_ground = 4'h0;
    i_det_open_load = 4'h0;
endtask
task automatic t_fault;
    logic [4:0] src;
    for (int k = 0; k < 5; k++) begin
        src = 5'h01 << k;
        {i_dc_offset_fault[0], i_overtemperature_fault, i_undervoltage_fault,
            i_overvoltage_fault, i_overcurrent_fault[0]} = src;
        cyc(5);
        chk(o_ch_hiz[0], 1'b1);
        chk(o_ch_gain_level[5:0], 6'h0);
        src = 5'h00;
        {i_dc_offset_fault[0], i_overtemperature_fault, i_undervoltage_fault,
            i_overvoltage_fault, i_overcurrent_fault[0]} = src;
        cyc(6);
        chk(o_ch_hiz[0], 1'b0);
    end
    // Mute first, then request high impedance once the ramp is down
    i_play_cmd = 4'h0;
    cyc(10);
    i_hiz_cmd = 4'hf;
    cyc(2);
    chk(o_ch_hiz, 4'hf);
endtask
task automatic t_clip;
    logic [4:0] tbl [6] = '{5'h05, 5'h02, 5'h0b, 5'h0c, 5'h15, 5'h13};
    foreach (tbl[k]) begin
        i_clip_mode = tbl[k][4:3];
        i_clip_detect = {3'h0, tbl[k][2]};
        i_overtemperature_warning = tbl[k][1];
        cyc(6);
        chk(o_clip_warning_output, tbl[k][0]);
    end
    i_clip_detect = 4'h0;
    i_overtemperature_warning = 0;
endtask
task automatic t_tweet;
    int hits = 0;
    i_clip_mode = 2'h3;
    i_tweet_ch = 2'h1;
    i_tweet_start = 1;
    cyc(1);
    i_tweet_start = 0;
    chk(o_tweet_active, 1'b1);
    tone_en = 1;
    repeat (40) begin
        cyc(1);
        hits += o_clip_warning_output;
    end
    chk(hits > 0, 1'b1);
    i_clip_mode = 2'h0;
    cyc(4);
    hits = 0;
    repeat (24) begin
        cyc(1);
        hits += o_clip_warning_output;
    end
    chk(hits == 0, 1'b1);
    tone_en = 0;
    i_tweet_stop = 1;
    cyc(1);
    i_tweet_stop = 0;
    chk(o_tweet_active, 1'b0);
endtask
initial begin
    cyc(12);
    i_arst_n = 1;
    cyc(2);
    t_power_up;
    t_play;
    t_reduced;
    t_fault;
    t_clip;
    t_tweet;
    complete_run;
end
initial begin
    #100000;
    fails++;
    complete_run;
end
endmodule // tb
`default_nettype wire
